/* ddr_pkg.sv */
// Shared constants for the registered DDR command decode block.
// Assumes a single 200 MHz core clock and synchronous pin inputs.
package ddr_pkg;
  // Bus widths
  localparam int ADDR_W = 14;
  localparam int BA_W = 2;
  localparam int NBANK = 4;
  localparam int DQ_W = 72;
  localparam int DM_W = 9;
  // Strobe codes {row, column, write}, all active low
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_BT = 3'h6;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h0;
  // Address bit that carries auto precharge / precharge-all
  localparam int AP_BIT = 10;
  // Bank select on a mode load
  localparam logic [1:0] BA_MR = 2'h0;
  localparam logic [1:0] BA_EMR = 2'h1;
  // Base mode register layout
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_OP_LSB = 7;
  localparam int MR_DLLRST_BIT = 8;
  localparam int MR_KEEP_W = 7;
  // Operating mode values in bits 7 and up
  localparam logic [6:0] OP_NORMAL = 7'h00;
  localparam logic [6:0] OP_DLL_RST = 7'h02;
  // Latency codes
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_25 = 3'h6;
  localparam logic [6:0] MR_RST = 7'h00;
  // Extended mode register layout
  localparam int EMR_DLLDIS_BIT = 0;
  localparam int EMR_DRV_BIT = 1;
  // DLL settle time in clock cycles
  localparam int DLL_LOCK_CYC = 200;
  localparam logic [7:0] DLL_LOCK_MAX = 8'(DLL_LOCK_CYC);
  // Whole-cycle part of read latency
  localparam int RD_LAT_CYC = 2;
  // One-hot power states
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SREF = 2'b10
  } pwr_st_t;
endpackage

/* ddr_mode_regs.sv */
// Base and extended mode register storage with DLL reset pulse.
// Assumes loads arrive as one-cycle pulses from the command decoder.
module ddr_mode_regs
  import ddr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Load request
  input wire logic mrs_go,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  // Stored settings
  output logic [MR_KEEP_W-1:0] mr_r,
  output logic dll_dis_r,
  output logic drv_r,
  output logic dll_rst_r,
  output logic emr_wr_r,
  output logic mrs_bad_r
);
  // Operating-mode field of the opcode
  logic [6:0] op;
  assign op = addr[MR_OP_LSB +: 7];

  // Base register: only normal or DLL-reset loads are taken
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mr_r <= MR_RST;
    end else if (mrs_go && ba == BA_MR &&
                 (op == OP_NORMAL || op == OP_DLL_RST)) begin
      mr_r <= addr[MR_KEEP_W-1:0];
    end
  end

  // DLL reset never stored, so it clears itself after one cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dll_rst_r <= 1'b0;
    end else begin
      dll_rst_r <= mrs_go && ba == BA_MR && op == OP_DLL_RST;
    end
  end

  // Extended register: held until rewritten, QFC bit never kept
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dll_dis_r <= 1'b0;
      drv_r <= 1'b0;
    end else if (mrs_go && ba == BA_EMR) begin
      dll_dis_r <= addr[EMR_DLLDIS_BIT];
      drv_r <= addr[EMR_DRV_BIT];
    end
  end

  // Event flags: extended write, reserved bank or mode code
  always_ff @(posedge core_clk) begin
    if (reset) begin
      emr_wr_r <= 1'b0;
      mrs_bad_r <= 1'b0;
    end else begin
      emr_wr_r <= mrs_go && ba == BA_EMR;
      mrs_bad_r <= mrs_go && (ba[1] || (ba == BA_MR &&
                   op != OP_NORMAL && op != OP_DLL_RST));
    end
  end
endmodule

/* ddr_read_timer.sv */
// Read latency timer: marks when first read data is launched.
// Assumes rd_go is a one-cycle pulse in the cycle after edge n.
module ddr_read_timer
  import ddr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Read start and half-cycle select
  input wire logic rd_go,
  input wire logic half,
  // First data on rising edge n+2, or falling edge after n+2
  output logic rd_rise_r,
  output logic rd_fall_r
);
  // One stage of delay; the output flop gives the second
  logic go_d;
  logic half_d;

  // Stage one, latency sampled with the command
  always_ff @(posedge core_clk) begin
    if (reset) begin
      go_d <= 1'b0;
      half_d <= 1'b0;
    end else begin
      go_d <= rd_go;
      half_d <= half;
    end
  end

  // Output flops, high in the cycle after edge n+2
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_rise_r <= 1'b0;
      rd_fall_r <= 1'b0;
    end else begin
      rd_rise_r <= go_d && !half_d;
      rd_fall_r <= go_d && half_d;
    end
  end
endmodule

/* ddr_cmd_decode.sv */
// Command register, decoder, bank/refresh state and write masking.
// Assumes the controller keeps mode loads to idle banks and legal codes.
// Behaviour
// - Read latency two or two-and-half cycles only
// - First read data at capture edge plus latency
// - Normal mode needs operating bits all zero
// - Bit eight alone requests a DLL reset
// - Bank bit zero selects extended register
// - Extended register holds until rewritten
// - DLL enabled again on self refresh exit
// - Strobe patterns decode the command set
// - High chip select acts as no operation
// - Bank bits and column; bit ten auto precharge
// - Precharge one bank or all by bit ten
// - Refresh is auto or self by enable
// - Refresh uses internal row counter only
// - Bank bits pick base or extended register
// - Mask high blocks the matching write data
// - No switch control output exists
// - Mode bits hold length, type and latency
// - DLL reset bit clears itself
// - Commands pass with two register delays
module ddr_cmd_decode
  import ddr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Command pins from the controller
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  // Write data with mask
  input wire logic wr_valid,
  input wire logic [DQ_W-1:0] wr_data,
  input wire logic [DM_W-1:0] dm,
  // Registered command toward the memory devices
  output logic mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic mem_cke,
  output logic [BA_W-1:0] mem_ba,
  output logic [ADDR_W-1:0] mem_addr,
  // Decoded command pulses
  output logic cmd_act_r,
  output logic cmd_read_r,
  output logic cmd_write_r,
  output logic cmd_bt_r,
  output logic cmd_pre_r,
  output logic cmd_aref_r,
  output logic cmd_sref_r,
  output logic cmd_mrs_r,
  output logic auto_pre_r,
  output logic cmd_bad_r,
  // Mode settings and status
  output logic [2:0] burst_len,
  output logic burst_il,
  output logic [2:0] rd_lat,
  output logic drv_weak,
  output logic dll_on,
  output logic dll_rst,
  output logic dll_ready_r,
  output logic read_early_r,
  output logic mrs_bad,
  output logic in_sref,
  output logic [NBANK-1:0] bank_open_r,
  output logic [ADDR_W-1:0] ref_row_r,
  // Read launch marks
  output logic rd_rise,
  output logic rd_fall,
  // Masked write toward the devices
  output logic [DM_W-1:0] wr_en_r,
  output logic [DQ_W-1:0] wr_data_r
);
  // Input register stage
  logic cs_q, ras_q, cas_q, we_q, cke_q;
  logic [BA_W-1:0] ba_q;
  logic [ADDR_W-1:0] addr_q;
  // Power state
  pwr_st_t st_r;
  pwr_st_t st_nxt;
  // Decoded strobes of the input stage
  logic sel;
  logic [2:0] code;
  // Mode register outputs
  logic [MR_KEEP_W-1:0] mr;
  logic dll_dis, emr_wr;
  // Forced DLL enable after self refresh exit
  logic dll_force_r;
  logic [7:0] lock_cnt_r;
  logic dll_on_d_r;

  // Sample the pins on the rising edge only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cs_q <= 1'b1;
      ras_q <= 1'b1;
      cas_q <= 1'b1;
      we_q <= 1'b1;
      cke_q <= 1'b0;
      ba_q <= '0;
      addr_q <= '0;
    end else begin
      cs_q <= cs_n;
      ras_q <= ras_n;
      cas_q <= cas_n;
      we_q <= we_n;
      cke_q <= cke;
      ba_q <= ba;
      addr_q <= addr;
    end
  end

  // Pass the latched command on at the following edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mem_cs_n <= 1'b1;
      mem_ras_n <= 1'b1;
      mem_cas_n <= 1'b1;
      mem_we_n <= 1'b1;
      mem_cke <= 1'b0;
      mem_ba <= '0;
      mem_addr <= '0;
    end else begin
      mem_cs_n <= cs_q;
      mem_ras_n <= ras_q;
      mem_cas_n <= cas_q;
      mem_we_n <= we_q;
      mem_cke <= cke_q;
      mem_ba <= ba_q;
      mem_addr <= addr_q;
    end
  end

  // Chip select high is deselect; self refresh ignores all but enable
  assign sel = !cs_q && st_r == ST_RUN;
  assign code = {ras_q, cas_q, we_q};

  // Decode into one-cycle pulses aligned with the device stage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmd_act_r <= 1'b0;
      cmd_read_r <= 1'b0;
      cmd_write_r <= 1'b0;
      cmd_bt_r <= 1'b0;
      cmd_pre_r <= 1'b0;
      cmd_aref_r <= 1'b0;
      cmd_sref_r <= 1'b0;
      cmd_mrs_r <= 1'b0;
      cmd_bad_r <= 1'b0;
    end else begin
      cmd_act_r <= sel && cke_q && code == CMD_ACT;
      cmd_read_r <= sel && cke_q && code == CMD_RD;
      cmd_write_r <= sel && cke_q && code == CMD_WR;
      cmd_bt_r <= sel && cke_q && code == CMD_BT;
      cmd_pre_r <= sel && cke_q && code == CMD_PRE;
      cmd_aref_r <= sel && cke_q && code == CMD_REF;
      cmd_sref_r <= sel && !cke_q && code == CMD_REF;
      cmd_mrs_r <= sel && cke_q && code == CMD_MRS;
      // Low enable with any selected command but refresh or no operation is not defined
      cmd_bad_r <= sel && !cke_q && code != CMD_REF &&
                   code != CMD_NOP;
    end
  end

  // Auto precharge flag is per access, never remembered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      auto_pre_r <= 1'b0;
    end else begin
      auto_pre_r <= sel && cke_q && addr_q[AP_BIT] &&
                    (code == CMD_RD || code == CMD_WR);
    end
  end

  // Open-bank tracking; auto precharge closes the bank at once
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bank_open_r <= '0;
    end else if (sel && cke_q) begin
      if (code == CMD_ACT) begin
        bank_open_r[ba_q] <= 1'b1;
      end else if (code == CMD_PRE && addr_q[AP_BIT]) begin
        bank_open_r <= '0;
      end else if (code == CMD_PRE) begin
        bank_open_r[ba_q] <= 1'b0;
      end else if ((code == CMD_RD || code == CMD_WR) &&
                   addr_q[AP_BIT]) begin
        bank_open_r[ba_q] <= 1'b0;
      end
    end
  end

  // Power state: self refresh until enable returns high
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_RUN: begin
        if (sel && !cke_q && code == CMD_REF) begin
          st_nxt = ST_SREF;
        end
      end
      ST_SREF: begin
        if (cke_q) begin
          st_nxt = ST_RUN;
        end
      end
      default: begin
        st_nxt = ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r <= ST_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign in_sref = st_r == ST_SREF;

  // Internal refresh row counter, address pins play no part
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ref_row_r <= '0;
    end else if (cmd_aref_r) begin
      ref_row_r <= ref_row_r + 1'b1;
    end
  end

  // Mode and extended mode storage
  ddr_mode_regs u_mode (
    .core_clk(core_clk),
    .reset(reset),
    .mrs_go(cmd_mrs_r),
    .ba(mem_ba),
    .addr(mem_addr),
    .mr_r(mr),
    .dll_dis_r(dll_dis),
    .drv_r(drv_weak),
    .dll_rst_r(dll_rst),
    .emr_wr_r(emr_wr),
    .mrs_bad_r(mrs_bad)
  );
  assign burst_len = mr[MR_BL_LSB +: 3];
  assign burst_il = mr[MR_BT_BIT];
  assign rd_lat = mr[MR_CL_LSB +: 3];

  // Leaving self refresh forces the DLL on without touching storage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dll_force_r <= 1'b0;
    end else if (st_r == ST_SREF && st_nxt == ST_RUN) begin
      dll_force_r <= 1'b1;
    end else if (emr_wr) begin
      dll_force_r <= 1'b0;
    end
  end
  assign dll_on = !dll_dis || dll_force_r;

  // Settle counter restarted by enable or reset of the DLL
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dll_on_d_r <= 1'b0;
      lock_cnt_r <= '0;
      dll_ready_r <= 1'b0;
    end else begin
      dll_on_d_r <= dll_on;
      if (!dll_on || (dll_on && !dll_on_d_r) || dll_rst) begin
        lock_cnt_r <= '0;
        dll_ready_r <= 1'b0;
      end else if (lock_cnt_r != DLL_LOCK_MAX) begin
        lock_cnt_r <= lock_cnt_r + 1'b1;
      end else begin
        dll_ready_r <= 1'b1;
      end
    end
  end

  // Flag a read the controller issued before the DLL settled
  always_ff @(posedge core_clk) begin
    if (reset) begin
      read_early_r <= 1'b0;
    end else begin
      read_early_r <= cmd_read_r && !dll_ready_r;
    end
  end

  // Reserved latency codes fall back to whole-cycle timing
  ddr_read_timer u_rd (
    .core_clk(core_clk),
    .reset(reset),
    .rd_go(cmd_read_r),
    .half(rd_lat == CL_25),
    .rd_rise_r(rd_rise),
    .rd_fall_r(rd_fall)
  );

  // Mask high blocks its byte lane; data and mask travel together
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_en_r <= '0;
      wr_data_r <= '0;
    end else begin
      wr_en_r <= wr_valid ? ~dm : '0;
      wr_data_r <= wr_data;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_rd_lat_two: assert property (
    cmd_read_r && rd_lat == CL_2 |-> ##2 rd_rise && !rd_fall)
    else $error("read data not at edge n+2");
  chk_rd_lat_half: assert property (
    cmd_read_r && rd_lat == CL_25 |-> ##2 rd_fall && !rd_rise)
    else $error("half latency launch missing");
  chk_reg_delay: assert property (
    !$past(reset) && !$past(reset, 2) |->
      mem_ras_n == $past(ras_n, 2) && mem_addr == $past(addr, 2))
    else $error("command not delayed by register");
  chk_decode_read: assert property (
    cmd_read_r |-> !mem_cs_n && mem_ras_n && !mem_cas_n && mem_we_n)
    else $error("read decoded from wrong pattern");
  chk_deselect_nop: assert property (
    mem_cs_n |-> !(cmd_act_r || cmd_read_r || cmd_write_r ||
                   cmd_pre_r || cmd_mrs_r || cmd_aref_r))
    else $error("deselect produced a command");
  chk_pre_all: assert property (
    cmd_pre_r && mem_addr[AP_BIT] |-> bank_open_r == '0)
    else $error("precharge all left a bank open");
  chk_aref_row: assert property (
    cmd_aref_r |=> ref_row_r == $past(ref_row_r) + 1'b1)
    else $error("refresh row did not advance");
  chk_sref_entry: assert property (
    cmd_sref_r |-> in_sref)
    else $error("self refresh not entered");
  chk_dll_rst_clear: assert property (
    dll_rst |=> !dll_rst)
    else $error("DLL reset did not clear");
  chk_emr_hold: assert property (
    !emr_wr |-> $stable(drv_weak))
    else $error("extended register changed unwritten");
  chk_wr_mask: assert property (
    wr_valid && dm[0] |=> !wr_en_r[0])
    else $error("masked byte was written");
  chk_sref_dll: assert property (
    in_sref ##1 !in_sref |-> dll_on)
    else $error("DLL off after self refresh");

  cov_read_half: cover property (cmd_read_r && rd_lat == CL_25);
  cov_sref_exit: cover property (in_sref ##1 !in_sref);
  cov_dll_reset: cover property (dll_rst);
endmodule

/* ddr_ctrl_model.sv */
// Controller model: drives command pins and write beats for the bench.
// Assumes the bench calls its tasks; pins change on falling edges only.
module ddr_ctrl_model
  import ddr_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Command pins
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic cke,
  output logic [BA_W-1:0] ba,
  output logic [ADDR_W-1:0] addr,
  // Write data with mask
  output logic wr_valid,
  output logic [DQ_W-1:0] wr_data,
  output logic [DM_W-1:0] dm
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle pins at time zero, clock enable low until first command
  initial begin
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = CMD_NOP;
    cke = 1'b0;
    ba = '0;
    addr = '0;
    wr_valid = 1'b0;
    wr_data = '0;
    dm = '0;
  end

  // One command for one cycle; callers keep mode loads legal and idle
  task automatic issue(input logic sel, input logic [2:0] code,
      input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a, input logic k);
    @(negedge core_clk);
    cs_n = sel;
    {ras_n, cas_n, we_n} = code;
    ba = b;
    addr = a;
    cke = k;
    @(negedge core_clk);
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = CMD_NOP;
    // Released lines flip so a stale value never looks valid
    ba = ~b;
    addr = ~a;
  endtask

  // One write beat with its mask, then the lines flip
  task automatic beat(input logic [DQ_W-1:0] d, input logic [DM_W-1:0] m);
    @(negedge core_clk);
    wr_valid = 1'b1;
    wr_data = d;
    dm = m;
    @(negedge core_clk);
    wr_valid = 1'b0;
    wr_data = ~d;
    dm = ~m;
  endtask
endmodule

/* ddr_cmd_decode_bench.sv */
// Self-checking bench for the registered DDR command decode block.
// Assumes ddr_pkg, the design and ddr_ctrl_model are compiled first.
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
  err_count++; $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module ddr_cmd_decode_bench
  import ddr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Stimulus side and the observed buses that share its widths
  logic core_clk, reset, cs_n, ras_n, cas_n, we_n, cke, wr_valid;
  logic [BA_W-1:0] ba, mem_ba;
  logic [ADDR_W-1:0] addr, mem_addr, ref_row_r;
  logic [DQ_W-1:0] wr_data, wr_data_r;
  logic [DM_W-1:0] dm, wr_en_r;
  // Observed side
  logic mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_cke;
  logic cmd_act_r, cmd_read_r, cmd_write_r, cmd_bt_r, cmd_pre_r;
  logic cmd_aref_r, cmd_sref_r, cmd_mrs_r, auto_pre_r, cmd_bad_r;
  logic [2:0] burst_len, rd_lat;
  logic burst_il, drv_weak, dll_on, dll_rst, dll_ready_r, read_early_r;
  logic mrs_bad, in_sref, rd_rise, rd_fall, seen;
  logic [NBANK-1:0] bank_open_r;
  int err_count;
  int tests_run;
  // The eight command pulses in one vector, activate first
  wire logic [7:0] pulses = {cmd_act_r, cmd_read_r, cmd_write_r, cmd_bt_r,
    cmd_pre_r, cmd_aref_r, cmd_sref_r, cmd_mrs_r};
  // Table of the plain commands, in pulse order
  logic [2:0] codes [6] = '{CMD_ACT, CMD_RD, CMD_WR, CMD_BT, CMD_PRE, CMD_REF};

  ddr_cmd_decode ddr_cmd_decode_i (.core_clk(core_clk), .reset(reset),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke),
    .ba(ba), .addr(addr), .wr_valid(wr_valid), .wr_data(wr_data), .dm(dm),
    .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
    .mem_we_n(mem_we_n), .mem_cke(mem_cke), .mem_ba(mem_ba),
    .mem_addr(mem_addr), .cmd_act_r(cmd_act_r), .cmd_read_r(cmd_read_r),
    .cmd_write_r(cmd_write_r), .cmd_bt_r(cmd_bt_r), .cmd_pre_r(cmd_pre_r),
    .cmd_aref_r(cmd_aref_r), .cmd_sref_r(cmd_sref_r), .cmd_mrs_r(cmd_mrs_r),
    .auto_pre_r(auto_pre_r), .cmd_bad_r(cmd_bad_r), .burst_len(burst_len),
    .burst_il(burst_il), .rd_lat(rd_lat), .drv_weak(drv_weak),
    .dll_on(dll_on), .dll_rst(dll_rst), .dll_ready_r(dll_ready_r),
    .read_early_r(read_early_r), .mrs_bad(mrs_bad), .in_sref(in_sref),
    .bank_open_r(bank_open_r), .ref_row_r(ref_row_r), .rd_rise(rd_rise),
    .rd_fall(rd_fall), .wr_en_r(wr_en_r), .wr_data_r(wr_data_r));

  ddr_ctrl_model ctl_i (.core_clk(core_clk), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .cke(cke), .ba(ba), .addr(addr),
    .wr_valid(wr_valid), .wr_data(wr_data), .dm(dm));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Settle just past the next rising edge
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  // Command, then look at the cycle its pulse stands
  task automatic cmd(input logic s, input logic [2:0] c,
      input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a, input logic k);
    ctl_i.issue(s, c, b, a, k);
    step();
  endtask

  // Mode load, then look once the settings have landed
  task automatic mode(input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a);
    cmd(1'b0, CMD_MRS, b, a, 1'b1);
    `CHK("mrs_pulse", 1'b1, cmd_mrs_r)
    step();
  endtask

  // Read and check which edge launches the first data
  task automatic rd_chk(input logic r, input logic f);
    cmd(1'b0, CMD_RD, 2'h0, 14'h0000, 1'b1);
    `CHK("read_pulse", 1'b1, cmd_read_r)
    step();
    `CHK("read_early", 1'b0, read_early_r)
    step();
    `CHK("rd_rise", r, rd_rise)
    `CHK("rd_fall", f, rd_fall)
  endtask

  // Closing report and verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    err_count = 0;
    tests_run = 0;
    reset = 1'b1;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    step();
    `CHK("dll_on", 1'b1, dll_on)
    `CHK("dll_ready", 1'b0, dll_ready_r)
    `CHK("bank_open", 4'h0, bank_open_r)
    for (int i = 0; i < 400 && dll_ready_r !== 1'b1; i++) step();
    `CHK("dll_ready", 1'b1, dll_ready_r)
    if (dll_ready_r !== 1'b1) complete_run();
    $display("test reset done");
    // Base mode loads and both latencies
    mode(2'h0, 14'h0022);
    `CHK("burst_len", 3'h2, burst_len)
    `CHK("rd_lat", CL_2, rd_lat)
    `CHK("dll_rst", 1'b0, dll_rst)
    rd_chk(1'b1, 1'b0);
    mode(2'h0, 14'h006b);
    `CHK("burst_il", 1'b1, burst_il)
    rd_chk(1'b0, 1'b1);
    mode(2'h0, 14'h0122);
    `CHK("dll_rst", 1'b1, dll_rst)
    step();
    `CHK("dll_rst", 1'b0, dll_rst)
    `CHK("dll_ready", 1'b0, dll_ready_r)
    `CHK("rd_lat", CL_2, rd_lat)
    // Reserved bank select changes nothing
    cmd(1'b0, CMD_MRS, 2'h2, 14'h0062, 1'b1);
    seen = 1'b0;
    repeat (3) begin
      seen = seen | mrs_bad;
      step();
    end
    `CHK("mrs_bad", 1'b1, seen)
    `CHK("rd_lat", CL_2, rd_lat)
    mode(2'h1, 14'h0003);
    `CHK("drv_weak", 1'b1, drv_weak)
    `CHK("dll_on", 1'b0, dll_on)
    mode(2'h0, 14'h0022);
    `CHK("drv_weak", 1'b1, drv_weak)
    $display("test mode done");
    // Every plain command, then deselect and no-operation
    for (int i = 0; i < 6; i++) begin
      cmd(1'b0, codes[i], 2'h1, 14'h0005, 1'b1);
      `CHK("pulses", 8'h80 >> i, pulses)
      `CHK("mem_cmd", {1'b0, codes[i]},
        {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n})
      `CHK("mem_addr", 14'h0005, mem_addr)
      `CHK("mem_ba", 2'h1, mem_ba)
    end
    // Row counter steps one cycle after the refresh pulse
    step();
    `CHK("ref_row", 14'h0001, ref_row_r)
    // Selected command other than refresh or no operation with enable low is flagged
    cmd(1'b0, CMD_ACT, 2'h0, 14'h0000, 1'b0);
    `CHK("cmd_bad", 1'b1, cmd_bad_r)
    `CHK("bad_pulses", 8'h00, pulses)
    `CHK("mem_cke", 1'b0, mem_cke)
    cmd(1'b1, CMD_MRS, 2'h0, 14'h0000, 1'b1);
    `CHK("deselect", 8'h00, pulses)
    cmd(1'b0, CMD_NOP, 2'h0, 14'h0000, 1'b1);
    `CHK("nop", 8'h00, pulses)
    $display("test decode done");
    // Bank open and close paths
    cmd(1'b0, CMD_ACT, 2'h0, 14'h0011, 1'b1);
    cmd(1'b0, CMD_ACT, 2'h2, 14'h0011, 1'b1);
    cmd(1'b0, CMD_ACT, 2'h3, 14'h0011, 1'b1);
    cmd(1'b0, CMD_PRE, 2'h0, 14'h0000, 1'b1);
    step();
    `CHK("bank_open", 4'hc, bank_open_r)
    cmd(1'b0, CMD_WR, 2'h2, 14'h0400, 1'b1);
    `CHK("auto_pre", 1'b1, auto_pre_r)
    step();
    `CHK("bank_open", 4'h8, bank_open_r)
    cmd(1'b0, CMD_PRE, 2'h1, 14'h0400, 1'b1);
    step();
    `CHK("bank_open", 4'h0, bank_open_r)
    $display("test banks done");
    // Masked write beat
    ctl_i.beat({9{8'h5a}}, 9'h0a5);
    `CHK("wr_en", 9'h15a, wr_en_r)
    `CHK("wr_data", {9{8'h5a}}, wr_data_r)
    $display("test mask done");
    // Self refresh entry, blocked read, exit
    cmd(1'b0, CMD_REF, 2'h3, 14'h3fff, 1'b0);
    `CHK("sref", 8'h02, pulses)
    step();
    `CHK("in_sref", 1'b1, in_sref)
    cmd(1'b0, CMD_RD, 2'h0, 14'h0000, 1'b0);
    `CHK("blocked", 8'h00, pulses)
    cmd(1'b0, CMD_NOP, 2'h0, 14'h0000, 1'b1);
    step();
    `CHK("in_sref", 1'b0, in_sref)
    `CHK("dll_on", 1'b1, dll_on)
    `CHK("drv_weak", 1'b1, drv_weak)
    $display("test self refresh done");
    complete_run();
  end
endmodule
